// [pmx_master.sv]
// Purpose: master transfer engine of an 8-bit parallel bus port
// Assumes: config inputs come from same-clock register logic
// Notes:   every output is a flop; pins reflect the current phase
module pmx_master (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // configuration
  input  wire logic        master_en,
  input  wire logic        intr_en,
  input  wire logic        ctrl_active_high,
  input  wire logic        wide_data_select,
  input  wire logic [1:0]  addr_mux_select,
  input  wire logic [1:0]  chip_select_config,
  input  wire logic [15:0] bus_addr,
  // data window access
  input  wire logic        dwin_rd_lo,
  input  wire logic        dwin_wr_lo,
  input  wire logic [15:0] dwin_wr_data,
  output logic      [15:0] data_window_reg,
  output logic             busy,
  output logic             irq,
  // external pins
  input  wire logic [7:0]  ext_data_in,
  output logic      [7:0]  ext_data_out,
  output logic             ext_data_oe,
  output logic      [7:0]  ext_addr_low_pins,
  output logic      [7:0]  ext_addr_high_pins,
  output logic             chip_sel1_pin,
  output logic             chip_sel2_pin,
  output logic             read_strobe_pin,
  output logic             write_strobe_pin,
  output logic             addr_latch_low_strobe,
  output logic             addr_latch_high_strobe
);

  pmx_pkg::pmx_state_e state_q, state_d;
  logic [3:0]  cnt_q, cnt_d;
  logic        hi_q, hi_d;
  logic        wr_q, wr_d;
  logic        wide_q, wide_d;
  logic        busy_q, busy_d;
  logic        irq_q, irq_d;
  logic [15:0] dwin_q, dwin_d;
  logic [15:0] addr_q, addr_d;
  logic [7:0]  rd_byte;
  logic        trig;
  logic        trig_wr;
  logic        byte_done;
  logic        last_d;
  logic [7:0]  hi_mask;
  pmx_pkg::pmx_state_e first_phase;

  // pin registers
  logic [7:0] dout_q, dout_d;
  logic       doe_q, doe_d;
  logic [7:0] alo_q, alo_d;
  logic [7:0] ahi_q, ahi_d;
  logic       cs1_q, cs1_d;
  logic       cs2_q, cs2_d;
  logic       rds_q, rds_d;
  logic       wrs_q, wrs_d;
  logic       all_q, all_d;
  logic       alh_q, alh_d;

  // data pins pass two flops before the capture logic reads them
  pmx_sync #(
    .WIDTH (8)
  ) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (ext_data_in),
    .dout (rd_byte)
  );

  // trigger qualification; busy also blocks a second request
  always_comb begin
    trig    = master_en && !busy_q && (dwin_rd_lo || dwin_wr_lo);
    trig_wr = dwin_wr_lo; // a write wins if both arrive together
    first_phase = (addr_mux_select == pmx_pkg::MUX_DEMUX) ?
                  pmx_pkg::ST_SETUP : pmx_pkg::ST_ADDR_LO;
    byte_done = (state_q == pmx_pkg::ST_STROBE) &&
                (cnt_q == 4'h0);
  end

  // high address byte limited by chip select use; taken from the next
  // address so the first registered cycle of a transfer already shows it
  always_comb begin
    case (chip_select_config)
      pmx_pkg::CS_ONE: hi_mask = {1'b0, addr_d[14:8]};
      pmx_pkg::CS_TWO: hi_mask = {2'b00, addr_d[13:8]};
      default:         hi_mask = addr_d[15:8];
    endcase
  end

  // phase sequencing, data window and status
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    hi_d    = hi_q;
    wr_d    = wr_q;
    wide_d  = wide_q;
    dwin_d  = dwin_q;
    addr_d  = addr_q;
    irq_d   = 1'b0;
    case (state_q)
      pmx_pkg::ST_IDLE: begin
        if (trig) begin
          state_d = first_phase;
          hi_d    = 1'b0;
          wr_d    = trig_wr;
          wide_d  = wide_data_select;
          addr_d  = bus_addr;
          if (trig_wr) begin
            dwin_d = dwin_wr_data;
          end
        end
      end
      pmx_pkg::ST_ADDR_LO: begin
        state_d = (addr_mux_select == pmx_pkg::MUX_FULL) ?
                  pmx_pkg::ST_ADDR_HI : pmx_pkg::ST_SETUP;
      end
      pmx_pkg::ST_ADDR_HI: begin
        state_d = pmx_pkg::ST_SETUP;
      end
      pmx_pkg::ST_SETUP: begin
        state_d = pmx_pkg::ST_STROBE;
        cnt_d   = pmx_pkg::STROBE_LAST;
      end
      pmx_pkg::ST_STROBE: begin
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else begin
          // capture at the strobe's last cycle, held by the external part
          if (!wr_q) begin
            if (hi_q) begin
              dwin_d[15:8] = rd_byte;
            end else begin
              dwin_d[7:0] = rd_byte;
            end
          end
          irq_d = intr_en;
          if (wide_q && !hi_q) begin
            hi_d    = 1'b1;
            state_d = first_phase;
          end else if (trig) begin
            // back to back: the final cycle shows no busy
            state_d = first_phase;
            hi_d    = 1'b0;
            wr_d    = trig_wr;
            wide_d  = wide_data_select;
            addr_d  = bus_addr;
            if (trig_wr) begin
              dwin_d = dwin_wr_data;
            end
          end else begin
            state_d = pmx_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        state_d = pmx_pkg::ST_IDLE;
      end
    endcase
    // disabling master operation aborts any transfer at once
    if (!master_en) begin
      state_d = pmx_pkg::ST_IDLE;
      irq_d   = 1'b0;
      cnt_d   = 4'h0;
    end
    last_d = !wide_d || hi_d;
    busy_d = (state_d != pmx_pkg::ST_IDLE) &&
             !((state_d == pmx_pkg::ST_STROBE) && (cnt_d == 4'h0) &&
               last_d);
  end

  // pins follow the next phase so they are registered with it
  always_comb begin
    logic act;
    act   = (state_d != pmx_pkg::ST_IDLE);
    dout_d = pmx_pkg::BYTE_RST;
    doe_d  = 1'b0;
    alo_d  = pmx_pkg::BYTE_RST;
    ahi_d  = pmx_pkg::BYTE_RST;
    all_d  = 1'b0;
    alh_d  = 1'b0;
    case (state_d)
      pmx_pkg::ST_ADDR_LO: begin
        dout_d = addr_d[7:0];
        doe_d  = 1'b1;
        all_d  = 1'b1;
      end
      pmx_pkg::ST_ADDR_HI: begin
        dout_d = hi_mask;
        doe_d  = 1'b1;
        alh_d  = 1'b1;
      end
      pmx_pkg::ST_SETUP, pmx_pkg::ST_STROBE: begin
        dout_d = hi_d ? dwin_d[15:8] : dwin_d[7:0];
        doe_d  = wr_d;
      end
      default: begin
        doe_d = 1'b0;
      end
    endcase
    // address pins not used for multiplexing carry the address directly
    if (act && addr_mux_select == pmx_pkg::MUX_DEMUX) begin
      alo_d = addr_d[7:0];
    end
    if (act && addr_mux_select != pmx_pkg::MUX_FULL) begin
      ahi_d = hi_mask;
    end
    cs1_d = act && (chip_select_config != pmx_pkg::CS_NONE) && addr_d[14];
    cs2_d = act && (chip_select_config == pmx_pkg::CS_TWO) && addr_d[15];
    rds_d = (state_d == pmx_pkg::ST_STROBE) && !wr_d;
    wrs_d = (state_d == pmx_pkg::ST_STROBE) && wr_d;
    // polarity applied last so every control shares one setting
    if (!ctrl_active_high) begin
      cs1_d = !cs1_d;
      cs2_d = !cs2_d;
      rds_d = !rds_d;
      wrs_d = !wrs_d;
      all_d = !all_d;
      alh_d = !alh_d;
    end
  end

  // state and pin registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= pmx_pkg::ST_IDLE;
      cnt_q   <= 4'h0;
      hi_q    <= 1'b0;
      wr_q    <= 1'b0;
      wide_q  <= 1'b0;
      busy_q  <= 1'b0;
      irq_q   <= 1'b0;
      dwin_q  <= pmx_pkg::DWIN_RST;
      addr_q  <= pmx_pkg::ADDR_RST;
      dout_q  <= pmx_pkg::BYTE_RST;
      doe_q   <= 1'b0;
      alo_q   <= pmx_pkg::BYTE_RST;
      ahi_q   <= pmx_pkg::BYTE_RST;
      cs1_q   <= 1'b0;
      cs2_q   <= 1'b0;
      rds_q   <= 1'b0;
      wrs_q   <= 1'b0;
      all_q   <= 1'b0;
      alh_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      hi_q    <= hi_d;
      wr_q    <= wr_d;
      wide_q  <= wide_d;
      busy_q  <= busy_d;
      irq_q   <= irq_d;
      dwin_q  <= dwin_d;
      addr_q  <= addr_d;
      dout_q  <= dout_d;
      doe_q   <= doe_d;
      alo_q   <= alo_d;
      ahi_q   <= ahi_d;
      cs1_q   <= cs1_d;
      cs2_q   <= cs2_d;
      rds_q   <= rds_d;
      wrs_q   <= wrs_d;
      all_q   <= all_d;
      alh_q   <= alh_d;
    end
  end

  // outputs straight from flops
  assign data_window_reg        = dwin_q;
  assign busy                   = busy_q;
  assign irq                    = irq_q;
  assign ext_data_out           = dout_q;
  assign ext_data_oe            = doe_q;
  assign ext_addr_low_pins      = alo_q;
  assign ext_addr_high_pins     = ahi_q;
  assign chip_sel1_pin          = cs1_q;
  assign chip_sel2_pin          = cs2_q;
  assign read_strobe_pin        = rds_q;
  assign write_strobe_pin       = wrs_q;
  assign addr_latch_low_strobe  = all_q;
  assign addr_latch_high_strobe = alh_q;

  // assertion helpers: strobe levels independent of polarity
  logic rd_on;
  logic wr_on;
  assign rd_on = (rds_q == ctrl_active_high);
  assign wr_on = (wrs_q == ctrl_active_high);

  property p_rd_start;
    @(posedge clk) disable iff (rst)
    master_en && !busy_q && dwin_rd_lo && !dwin_wr_lo && master_en
    |=> master_en |-> (state_q != pmx_pkg::ST_IDLE) && !wr_q;
  endproperty
  a_rd_start: assert property (p_rd_start)
    else $error("read trigger did not start a bus read");

  property p_rd_capture;
    @(posedge clk) disable iff (rst)
    byte_done && !wr_q && !hi_q && master_en
    |=> dwin_q[7:0] == $past(rd_byte);
  endproperty
  a_rd_capture: assert property (p_rd_capture)
    else $error("read byte not captured into low byte");

  property p_wide_second;
    @(posedge clk) disable iff (rst)
    byte_done && wide_q && !hi_q && master_en
    |=> hi_q && (state_q != pmx_pkg::ST_IDLE);
  endproperty
  a_wide_second: assert property (p_wide_second)
    else $error("wide transfer skipped its second byte");

  property p_wr_data;
    @(posedge clk) disable iff (rst)
    (state_q == pmx_pkg::ST_STROBE) && wr_q
    |-> ext_data_oe && (ext_data_out == (hi_q ? dwin_q[15:8]
                                              : dwin_q[7:0]));
  endproperty
  a_wr_data: assert property (p_wr_data)
    else $error("write byte not on data pins during strobe");

  property p_wr_strobe;
    @(posedge clk) disable iff (rst)
    (state_q == pmx_pkg::ST_SETUP) && wr_q && master_en
    ##1 master_en[*3] |-> $past(wr_on, 2) && $past(wr_on) && wr_on;
  endproperty
  a_wr_strobe: assert property (p_wr_strobe)
    else $error("write strobe not held for three cycles");

  property p_busy_final;
    @(posedge clk) disable iff (rst)
    byte_done && (!wide_q || hi_q) |-> !busy_q;
  endproperty
  a_busy_final: assert property (p_busy_final)
    else $error("busy shown in the final cycle");

  property p_busy_mid;
    @(posedge clk) disable iff (rst)
    (state_q == pmx_pkg::ST_SETUP) |-> busy_q;
  endproperty
  a_busy_mid: assert property (p_busy_mid)
    else $error("busy low in the middle of a transfer");

  property p_no_busy_off;
    @(posedge clk) disable iff (rst)
    !master_en |=> !busy_q && (state_q == pmx_pkg::ST_IDLE);
  endproperty
  a_no_busy_off: assert property (p_no_busy_off)
    else $error("busy while master operation disabled");

  property p_ignore_busy;
    @(posedge clk) disable iff (rst)
    busy_q && wr_q && dwin_wr_lo |=> $stable(dwin_q) && $stable(addr_q);
  endproperty
  a_ignore_busy: assert property (p_ignore_busy)
    else $error("trigger taken while busy");

  property p_irq;
    @(posedge clk) disable iff (rst)
    byte_done && intr_en && master_en |=> irq_q;
  endproperty
  a_irq: assert property (p_irq)
    else $error("no interrupt after a completed bus cycle");

  property p_mux_lo;
    @(posedge clk) disable iff (rst)
    (state_q == pmx_pkg::ST_ADDR_LO) |->
      ext_data_oe && (ext_data_out == addr_q[7:0]) &&
      (addr_latch_low_strobe == ctrl_active_high);
  endproperty
  a_mux_lo: assert property (p_mux_lo)
    else $error("low address byte or latch missing");

  property p_mux_hi;
    @(posedge clk) disable iff (rst)
    (state_q == pmx_pkg::ST_ADDR_HI) |->
      (ext_data_out == hi_mask) &&
      (addr_latch_high_strobe == ctrl_active_high);
  endproperty
  a_mux_hi: assert property (p_mux_hi)
    else $error("high address byte wrongly masked or unlatched");

endmodule

// [pmx_pkg.sv]
// Purpose: shared constants for the parallel bus master transfer engine
// Assumes: 250 MHz system clock, one byte lane on the external pins
// Notes:   phase and strobe counts are derived here, not in the modules
package pmx_pkg;

  // address multiplexing select encodings
  localparam logic [1:0] MUX_DEMUX   = 2'h0;
  localparam logic [1:0] MUX_PARTIAL = 2'h1;
  localparam logic [1:0] MUX_FULL    = 2'h2;

  // chip select configuration encodings
  localparam logic [1:0] CS_NONE = 2'h0;
  localparam logic [1:0] CS_ONE  = 2'h1;
  localparam logic [1:0] CS_TWO  = 2'h2;

  // clock and strobe timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int STROBE_NS     = 12;
  // least time rounds up, never below one cycle
  localparam int STROBE_CYC_RAW =
    (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_CYC_RAW < 1) ? 1 : STROBE_CYC_RAW;
  localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYC - 1);

  // synchroniser depth for the data pins
  localparam int SYNC_STAGES = 2;

  // reset values
  localparam logic [15:0] DWIN_RST = 16'h0000;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0]  BYTE_RST = 8'h00;

  // transfer phases
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ADDR_LO = 3'b001,
    ST_ADDR_HI = 3'b010,
    ST_SETUP   = 3'b011,
    ST_STROBE  = 3'b100
  } pmx_state_e;

endpackage

// [pmx_sync.sv]
// Purpose: two flip-flop synchroniser for the external data pins
// Assumes: pins are quasi-static while the read strobe is held
// Notes:   only the last stage may be read by other logic
module pmx_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // asynchronous input and synchronised output
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // first stage feeds the second stage only
  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;

endmodule

// [pmx_ext_dev.sv]
// Purpose: external byte peripheral with address latches on the master port
// Assumes: pins are looked at on the system clock, polarity given by pol
// Notes:   released data lines show the inverse of the last byte read
module pmx_ext_dev (
  // clock
  input  wire logic       clk,
  // board configuration
  input  wire logic       pol,
  input  wire logic [1:0] mux_sel,
  // bus pins
  input  wire logic [7:0] bus,
  input  wire logic [7:0] addr_lo,
  input  wire logic       rd_pin,
  input  wire logic       wr_pin,
  input  wire logic       al_pin,
  input  wire logic       ah_pin,
  output logic      [7:0] drv
);
  logic [7:0] mem [0:255];
  logic [7:0] lo_q, hi_q, rd_last, wr_prev, wr_last, adr;
  logic       rd_a, wr_a, al_a, ah_a, rd_p, wr_p, al_p, ah_p;
  int         n_rd, n_wr, n_al, n_ah;

  // strobe levels follow the chosen polarity, active high for lcd parts
  assign rd_a = (rd_pin == pol);
  assign wr_a = (wr_pin == pol);
  assign al_a = (al_pin == pol);
  assign ah_a = (ah_pin == pol);
  // multiplexed modes need our own latched low address byte
  assign adr = (mux_sel == 2'h0) ? addr_lo : lo_q;
  // never leave a stale byte on released lines
  assign drv = rd_a ? mem[adr] : ~rd_last;

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    {lo_q, hi_q, rd_last, wr_prev, wr_last} = '0;
    {rd_p, wr_p, al_p, ah_p} = '0;
    {n_rd, n_wr, n_al, n_ah} = '0;
  end

  // address latches, write capture and event counts
  always @(posedge clk) begin
    if (al_a) lo_q <= bus;
    if (ah_a) hi_q <= bus;
    if (rd_a) rd_last <= mem[adr];
    if (wr_a) begin
      mem[adr] <= bus;
      wr_last  <= bus;
    end
    if (wr_a && !wr_p) wr_prev <= wr_last;
    if (wr_a && !wr_p) n_wr <= n_wr + 1;
    if (rd_a && !rd_p) n_rd <= n_rd + 1;
    if (al_a && !al_p) n_al <= n_al + 1;
    if (ah_a && !ah_p) n_ah <= n_ah + 1;
    {rd_p, wr_p, al_p, ah_p} <= {rd_a, wr_a, al_a, ah_a};
  end
endmodule

// [tb_top.sv]
// Purpose: self-checking bench for the parallel bus master engine
// Assumes: controls active high but in the polarity scenario, inputs
//          driven on falling edges
// Notes:   the bus peripheral model shares the data pins with the dut
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst = 1, master_en = 1, intr_en = 1, pol = 1;
  logic        wide = 0, rd_lo = 0, wr_lo = 0;
  logic [1:0]  mux = 2'h0, csc = 2'h0;
  logic [15:0] addr = 16'h0000, wdat = 16'h0000, dwin;
  logic        busy, irq, oe, cs1, cs2, rds, wrs, all_s, alh_s;
  logic [7:0]  dout, alo, ahi, drv, pins;
  int          n_errors = 0, checked = 0, cyc = 0, n_irq = 0;

  // whoever enables its driver owns the data lines
  assign pins = oe ? dout : drv;
  always #2 clk = ~clk;

  pmx_master dut (.clk(clk), .rst(rst), .master_en(master_en),
    .intr_en(intr_en), .ctrl_active_high(pol), .wide_data_select(wide),
    .addr_mux_select(mux), .chip_select_config(csc), .bus_addr(addr),
    .dwin_rd_lo(rd_lo), .dwin_wr_lo(wr_lo), .dwin_wr_data(wdat),
    .data_window_reg(dwin), .busy(busy), .irq(irq), .ext_data_in(pins),
    .ext_data_out(dout), .ext_data_oe(oe), .ext_addr_low_pins(alo),
    .ext_addr_high_pins(ahi), .chip_sel1_pin(cs1), .chip_sel2_pin(cs2),
    .read_strobe_pin(rds), .write_strobe_pin(wrs),
    .addr_latch_low_strobe(all_s), .addr_latch_high_strobe(alh_s));

  pmx_ext_dev mdl (.clk(clk), .pol(pol), .mux_sel(mux), .bus(pins),
    .addr_lo(alo), .rd_pin(rds), .wr_pin(wrs), .al_pin(all_s),
    .ah_pin(alh_s), .drv(drv));

  // interrupt pulse count and hang guard
  always @(posedge clk) begin
    cyc++;
    if (irq === 1'b1) n_irq++;
    if (cyc == 5000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // one-cycle trigger pulse from software
  task automatic trig(input logic wr, input logic [15:0] a, d);
    @(negedge clk);
    addr = a;
    wdat = d;
    wr_lo = wr;
    rd_lo = !wr;
    @(negedge clk);
    wr_lo = 1'b0;
    rd_lo = 1'b0;
  endtask

  // wait for busy to drop, then judge the pins in the final cycle;
  // poke lets the peripheral change its byte between the two halves
  task automatic finish_op(input logic wr, input logic [15:0] a,
                           input logic poke, input logic [7:0] nv);
    logic [7:0] hx;
    logic [7:0] ex_lo;
    logic [7:0] ex_hi;
    logic [1:0] cse;
    hx = (csc == 2'h1) ? {1'b0, a[14:8]} :
         (csc == 2'h2) ? {2'b00, a[13:8]} : a[15:8];
    ex_lo = (mux == 2'h0) ? a[7:0] : 8'h00;
    ex_hi = (mux != 2'h2) ? hx : 8'h00;
    cse = {csc != 2'h0 && a[14], csc == 2'h2 && a[15]} ^ {2{!pol}};
    for (int i = 0; i < 40 && busy !== 1'b0; i++) begin
      if (poke && irq === 1'b1) mdl.mem[a[7:0]] = nv;
      @(negedge clk);
    end
    chk({15'h0000, busy}, 16'h0000);
    chk({15'h0000, oe}, {15'h0000, wr});
    chk({14'h0000, rds, wrs}, {14'h0000, pol ^ wr, !(pol ^ wr)});
    chk({15'h0000, rds | wrs}, 16'h0001);
    chk({alo, ahi}, {ex_lo, ex_hi});
    chk({14'h0000, cs1, cs2}, {14'h0000, cse});
    repeat (2) @(negedge clk);
  endtask

  task automatic op(input logic wr, input logic [15:0] a, d,
                    input logic poke, input logic [7:0] nv);
    trig(wr, a, d);
    chk({15'h0000, busy}, 16'h0001);
    finish_op(wr, a, poke, nv);
  endtask

  task automatic s_write8();
    int k;
    k = n_irq;
    op(1'b1, 16'h0012, 16'h00A5, 1'b0, 8'h00);
    chk({8'h00, mdl.mem[8'h12]}, 16'h00A5);
    chk(16'(n_irq - k), 16'h0001);
  endtask

  task automatic s_read8();
    int r;
    r = mdl.n_rd;
    mdl.mem[8'h34] = 8'h5C;
    op(1'b0, 16'h0034, 16'h0000, 1'b0, 8'h00);
    chk({8'h00, dwin[7:0]}, 16'h005C);
    chk(16'(mdl.n_rd - r), 16'h0001);
  endtask

  // wide mode: two byte cycles per trigger, low byte first
  task automatic s_wide();
    int k, w;
    wide = 1'b1;
    k = n_irq;
    w = mdl.n_wr;
    op(1'b1, 16'h0040, 16'h3C5A, 1'b0, 8'h00);
    chk({mdl.wr_prev, mdl.wr_last}, 16'h5A3C);
    chk(16'(mdl.n_wr - w), 16'h0002);
    chk(16'(n_irq - k), 16'h0002);
    op(1'b0, 16'h0040, 16'h0000, 1'b1, 8'h99);
    chk(dwin, 16'h993C);
    wide = 1'b0;
  endtask

  // triggers while busy or with master disabled go nowhere
  task automatic s_busy();
    int w;
    mdl.mem[8'h51] = 8'h77;
    trig(1'b1, 16'h0050, 16'h0011);
    trig(1'b1, 16'h0051, 16'h0022);
    finish_op(1'b1, 16'h0050, 1'b0, 8'h00);
    chk({8'h00, mdl.mem[8'h51]}, 16'h0077);
    chk({8'h00, mdl.mem[8'h50]}, 16'h0011);
    chk({8'h00, dwin[7:0]}, 16'h0011);
    master_en = 1'b0;
    w = mdl.n_wr;
    trig(1'b1, 16'h0060, 16'h0033);
    repeat (4) @(negedge clk);
    chk({15'h0000, busy}, 16'h0000);
    chk(16'(mdl.n_wr - w), 16'h0000);
    master_en = 1'b1;
  endtask

  // both multiplexed mux modes against every chip select option
  task automatic s_mux();
    logic [7:0] hi_exp [3];
    int a, b;
    hi_exp = '{8'hF3, 8'h73, 8'h33};
    for (int m = 1; m < 3; m++) begin
      for (int c = 0; c < 3; c++) begin
        mux = 2'(m);
        csc = 2'(c);
        a = mdl.n_al;
        b = mdl.n_ah;
        op(1'b1, 16'hF3A7, 16'(8'h10 * m + c), 1'b0, 8'h00);
        chk({8'h00, mdl.lo_q}, 16'h00A7);
        chk({8'h00, mdl.mem[8'hA7]}, 16'(8'h10 * m + c));
        chk(16'(mdl.n_al - a), 16'h0001);
        chk(16'(mdl.n_ah - b), (m == 2) ? 16'h0001 : 16'h0000);
        if (m == 2) chk({8'h00, mdl.hi_q}, {8'h00, hi_exp[c]});
      end
    end
    mux = 2'h0;
    csc = 2'h0;
  endtask

  // active-low controls: strobe and chip select pins swap level, the write lands;
  // two idle cycles let the peripheral settle after the level swap
  task automatic s_pol();
    int w;
    pol = 1'b0;
    csc = 2'h1;
    repeat (2) @(negedge clk);
    w = mdl.n_wr;
    op(1'b1, 16'h4077, 16'h00C3, 1'b0, 8'h00);
    chk({8'h00, mdl.mem[8'h77]}, 16'h00C3);
    chk(16'(mdl.n_wr - w), 16'h0001);
    csc = 2'h0;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk({15'h0000, busy}, 16'h0000);
    s_write8();
    s_read8();
    s_wide();
    s_busy();
    s_mux();
    s_pol();
    summarize();
  end
endmodule
